// ===== common/sebm_pkg.sv
// Shared constants for the enhanced buffer serial master.
package sebm_pkg;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned COUNT_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam logic [2:0] PRESCALE_RESET = 3'h0;
   localparam logic [2:0] PRESCALE_SAFE_MAX = 3'h1;
   localparam int unsigned WAKE_NULL_ITEMS = 2;
   localparam logic [15:0] NULL_ITEM = 16'h0000;
   localparam int unsigned FRAMED_BIT_POS = 15;
   localparam int unsigned SYS_CLK_HZ = 20000000;
   localparam int unsigned SYS_CLK_NS = 1000000000 / SYS_CLK_HZ;
   typedef enum logic [1:0] {
      SEBM_IDLE = 2'b00,
      SEBM_LOAD = 2'b01,
      SEBM_SHIFT = 2'b10
   } sebm_state_type;
endpackage

// ===== core/sebm_master.sv
// Serial master with transmit and receive FIFOs in enhanced buffer mode.
// Operation
// R1 - In enhanced buffer mode, waking from sleep shifts out two zero items and captures two zero items.
// R2 - After such a wake-up, software reads the receive buffer twice to discard the zero items.
// R3 - Software should clear the module on bit before putting the device to sleep in enhanced buffer mode.
// R4 - With a combined prescale above 1:4 in enhanced mode, the transmit-full flag clears while data is unsent.
// R5 - Software should use a total prescale of 1:4 or less to avoid the early flag clearing.
// R6 - Software may count sent items with the receive-full flag or the element count instead.
// R7 - If pacing on the transmit-full flag, software waits half a serial clock after it clears before writing.
// R8 - Framed modes are unsupported and the framed-mode select bit must stay cleared.
// R9 - All other serial modes behave as normally defined.
// R10 - Enhanced buffer operation is chosen by setting the enhanced buffer select bit.
// R11 - The master makes the serial clock and shifts one item out and one in per transfer.
`timescale 1ns/1ps
module sebm_master #(
   parameter int unsigned DEPTH = sebm_pkg::FIFO_DEPTH,
   parameter int unsigned WIDTH = sebm_pkg::DATA_W
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic module_on_bit,
   input wire logic enhanced_buffer_select,
   input wire logic framed_mode_select,
   input wire logic word_mode,
   input wire logic clock_idle_high,
   input wire logic [2:0] prescale,
   input wire logic sleep_wake,
   input wire logic tx_write,
   input wire logic [WIDTH-1:0] tx_data,
   input wire logic rx_read,
   output logic [WIDTH-1:0] rx_data,
   output logic transmit_full_flag,
   output logic receive_full_flag,
   output logic [sebm_pkg::COUNT_W-1:0] buffer_element_count,
   output logic framed_error,
   output logic sck,
   output logic sdo,
   input wire logic sdi
);
   localparam int unsigned PW = $clog2(DEPTH);

   logic [WIDTH-1:0] tx_mem [DEPTH];
   logic [WIDTH-1:0] rx_mem [DEPTH];
   logic [PW-1:0] tx_wr, tx_rd, rx_wr, rx_rd;
   logic [PW:0] tx_cnt, rx_cnt;
   sebm_pkg::sebm_state_type state;
   logic [WIDTH-1:0] shift;
   logic [4:0] bits_left;
   logic [7:0] div_cnt;
   logic sck_phase;
   logic rx_bit;
   logic null_item;
   logic [1:0] wake_pending;
   logic in_sync1, in_sync2, in_sync3;

   ////////////////////////////////////////////////////////////////////////
   // Decode.

   wire enabled = module_on_bit & ~framed_mode_select;
   wire enhanced = enabled & enhanced_buffer_select;
   wire [PW:0] depth_eff = enhanced ? (PW+1)'(DEPTH) : (PW+1)'(1);
   wire tx_push = enabled & tx_write & (tx_cnt < depth_eff);
   wire rx_pop = rx_read & (rx_cnt != '0);
   wire slot_free = rx_cnt < depth_eff;
   wire have_tx = (tx_cnt != '0) | (wake_pending != 2'h0);
   wire start = enabled & (state == sebm_pkg::SEBM_IDLE) & have_tx & slot_free;
   wire [7:0] half_period = 8'h01 << prescale;
   wire tick = (div_cnt == half_period - 8'h01);
   wire [4:0] item_bits = word_mode ? 5'h10 : 5'h08;
   wire sample_edge = tick & ~sck_phase & (state == sebm_pkg::SEBM_SHIFT);
   wire shift_edge = tick & sck_phase & (state == sebm_pkg::SEBM_SHIFT);
   wire last_bit = shift_edge & (bits_left == 5'h01);
   wire use_null = (wake_pending != 2'h0);
   wire tx_pop = start & ~use_null;
   wire slow = prescale > sebm_pkg::PRESCALE_SAFE_MAX;
   wire [WIDTH-1:0] msb_mask = word_mode ? WIDTH'(1) << 15 : WIDTH'(1) << 7;

   // R4 early flag
   wire tx_full_raw = enhanced ? (tx_cnt == (PW+1)'(DEPTH)) : (tx_cnt != '0);
   wire tx_full_early = enhanced & slow & (state == sebm_pkg::SEBM_SHIFT) & (tx_cnt == (PW+1)'(DEPTH));

   ////////////////////////////////////////////////////////////////////////
   // Input synchroniser.

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         in_sync1 <= 1'b0;
         in_sync2 <= 1'b0;
         in_sync3 <= 1'b0;
      end else begin
         in_sync1 <= sdi;
         in_sync2 <= in_sync1;
         in_sync3 <= in_sync2;
      end
   end

   // Agreement of the last two stages filters a bit that is still settling.
   wire sdi_bit = (in_sync2 == in_sync3) ? in_sync3 : rx_bit;
   // The stored item must include the bit that enters on the last trailing edge.
   wire [WIDTH-1:0] next_shift = {shift[WIDTH-2:0], rx_bit};

   ////////////////////////////////////////////////////////////////////////
   // FIFOs.

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_wr <= '0;
         tx_rd <= '0;
         tx_cnt <= '0;
      end else if (!enabled) begin
         tx_wr <= '0;
         tx_rd <= '0;
         tx_cnt <= '0;
      end else begin
         if (tx_push) begin
            tx_mem[tx_wr] <= tx_data;
            tx_wr <= (tx_wr == PW'(DEPTH-1)) ? '0 : tx_wr + 1'b1;
         end
         if (tx_pop)
            tx_rd <= (tx_rd == PW'(DEPTH-1)) ? '0 : tx_rd + 1'b1;
         tx_cnt <= tx_cnt + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
      end
   end

   // R11 capture per transfer
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_wr <= '0;
         rx_rd <= '0;
         rx_cnt <= '0;
         rx_data <= '0;
      end else if (!enabled) begin
         rx_wr <= '0;
         rx_rd <= '0;
         rx_cnt <= '0;
      end else begin
         if (last_bit) begin
            if (null_item)
               rx_mem[rx_wr] <= sebm_pkg::NULL_ITEM;
            else
               rx_mem[rx_wr] <= word_mode ? next_shift : {8'h00, next_shift[7:0]};
            rx_wr <= (rx_wr == PW'(DEPTH-1)) ? '0 : rx_wr + 1'b1;
         end
         if (rx_pop) begin
            rx_data <= rx_mem[rx_rd];
            rx_rd <= (rx_rd == PW'(DEPTH-1)) ? '0 : rx_rd + 1'b1;
         end
         rx_cnt <= rx_cnt + (PW+1)'(last_bit) - (PW+1)'(rx_pop);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shifter and clock generator.

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= sebm_pkg::SEBM_IDLE;
         shift <= '0;
         bits_left <= 5'h00;
         div_cnt <= 8'h00;
         sck_phase <= 1'b0;
         wake_pending <= 2'h0;
         rx_bit <= 1'b0;
         null_item <= 1'b0;
      end else if (!enabled) begin
         state <= sebm_pkg::SEBM_IDLE;
         div_cnt <= 8'h00;
         sck_phase <= 1'b0;
         wake_pending <= 2'h0;
      end else begin
         // R1 wake null items
         if (sleep_wake & enhanced)
            wake_pending <= 2'(sebm_pkg::WAKE_NULL_ITEMS);
         else if (start & use_null)
            wake_pending <= wake_pending - 2'h1;
         unique case (state)
            sebm_pkg::SEBM_IDLE: begin
               div_cnt <= 8'h00;
               sck_phase <= 1'b0;
               if (start) begin
                  shift <= use_null ? sebm_pkg::NULL_ITEM : tx_mem[tx_rd];
                  null_item <= use_null;
                  bits_left <= item_bits;
                  state <= sebm_pkg::SEBM_LOAD;
               end
            end
            sebm_pkg::SEBM_LOAD:
               state <= sebm_pkg::SEBM_SHIFT;
            sebm_pkg::SEBM_SHIFT: begin
               div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
               // R11 clock and shift
               if (tick)
                  sck_phase <= ~sck_phase;
               if (sample_edge)
                  rx_bit <= sdi_bit;
               if (shift_edge) begin
                  shift <= next_shift;
                  bits_left <= bits_left - 5'h01;
                  if (last_bit)
                     state <= sebm_pkg::SEBM_IDLE;
               end
            end
            default:
               state <= sebm_pkg::SEBM_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs.

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sck <= 1'b0;
         sdo <= 1'b0;
         transmit_full_flag <= 1'b0;
         receive_full_flag <= 1'b0;
         buffer_element_count <= '0;
         framed_error <= 1'b0;
      end else begin
         sck <= clock_idle_high ^ (sck_phase & (state == sebm_pkg::SEBM_SHIFT));
         sdo <= (state != sebm_pkg::SEBM_IDLE) & ((shift & msb_mask) != '0);
         // R4 flag may clear early
         transmit_full_flag <= tx_full_raw & ~tx_full_early;
         // R9 normal mode flags
         receive_full_flag <= enhanced ? (rx_cnt == (PW+1)'(DEPTH)) : (rx_cnt != '0);
         buffer_element_count <= sebm_pkg::COUNT_W'(tx_cnt);
         // R8 framed unsupported
         framed_error <= module_on_bit & framed_mode_select;
      end
   end
endmodule

// ===== dv/sebm_master_properties.sv
// Concurrent checks on the ports of the enhanced buffer serial master.
`timescale 1ns/1ps
module sebm_master_checker (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic module_on_bit,
   input wire logic enhanced_buffer_select,
   input wire logic framed_mode_select,
   input wire logic clock_idle_high,
   input wire logic sleep_wake,
   input wire logic [sebm_pkg::COUNT_W-1:0] buffer_element_count,
   input wire logic framed_error,
   input wire logic sck
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_off2;
      !module_on_bit ##1 !module_on_bit;
   endsequence
   sequence s_frm2;
      framed_mode_select ##1 framed_mode_select;
   endsequence
   property p_frm_err;
      module_on_bit && framed_mode_select |=> framed_error;
   endproperty
   a_frm_err: assert property (p_frm_err) else $error("framed error missing");
   property p_frm_clr;
      !framed_mode_select |=> !framed_error;
   endproperty
   a_frm_clr: assert property (p_frm_clr) else $error("framed error spurious");
   property p_frm_idle;
      s_frm2 ##0 $stable(clock_idle_high) |-> sck == clock_idle_high;
   endproperty
   a_frm_idle: assert property (p_frm_idle) else $error("clock runs in framed mode");
   property p_off_idle;
      s_off2 ##0 $stable(clock_idle_high) |-> sck == clock_idle_high;
   endproperty
   a_off_idle: assert property (p_off_idle) else $error("clock not idle when off");
   property p_wake;
      enhanced_buffer_select && module_on_bit && !framed_mode_select && sleep_wake
         |-> ##[1:300] sck != clock_idle_high;
   endproperty
   a_wake: assert property (p_wake) else $error("wake nulls not queued");
   property p_nrm_wake;
      !enhanced_buffer_select && buffer_element_count == 0 && sleep_wake |=> buffer_element_count == 0;
   endproperty
   a_nrm_wake: assert property (p_nrm_wake) else $error("wake nulls in normal mode");
endmodule
bind sebm_master sebm_master_checker u_chk (.*);

// ===== dv/sebm_slave.sv
// Serial slave model answering every item with all ones.
`timescale 1ns/1ps
module sebm_slave (
   input wire logic sck,
   output logic sdi
);
   // reply data
   // All ones keeps real replies apart from the zero wake items.
   assign sdi = 1'b1;
endmodule

// ===== dv/test_sebm_master.sv
// Self-checking bench for the enhanced buffer serial master.
`timescale 1ns/1ps
module test_sebm_master;
   logic sys_clk = 0, reset_n = 0, module_on_bit = 0, enhanced_buffer_select = 0, framed_mode_select = 0;
   logic word_mode = 0, clock_idle_high = 0, sleep_wake = 0, tx_write = 0, rx_read = 0, sdi;
   logic [2:0] prescale = 3'h0;
   logic [15:0] tx_data = 16'h0000;
   logic [15:0] rx_data;
   logic transmit_full_flag, receive_full_flag, framed_error, sck, sdo;
   logic [3:0] buffer_element_count;
   int n_fail = 0, n_tests = 0;
   // Config bits are prescale, idle level, word mode, enhanced select; then data sent and reply.
   logic [15:0] row [4][3] = '{'{16'h0003, 16'hA5C3, 16'hFFFF}, '{16'h0005, 16'h005A, 16'h00FF},
      '{16'h000A, 16'h1234, 16'hFFFF}, '{16'h0015, 16'h00C3, 16'h00FF}};
   sebm_master u_sebm_master (.*);
   sebm_slave u_sebm_slave (.sck(sck), .sdi(sdi));
   initial forever #25 sys_clk = ~sys_clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input int n, input logic [15:0] d);
      tx_write = 1;
      repeat (n) begin
         tx_data = d;
         @(negedge sys_clk);
      end
      tx_write = 0;
   endtask
   task automatic rd(input logic [15:0] exp);
      int i;
      for (i = 0; i < 4000 && buffer_element_count !== 4'h0 && receive_full_flag !== 1'b1; i++)
         @(negedge sys_clk);
      if (i == 4000) begin
         n_fail++;
         print_verdict();
      end
      // Long enough for any item still in the shifter at the prescales used here.
      repeat (200) @(negedge sys_clk);
      rx_read = 1;
      @(negedge sys_clk);
      rx_read = 0;
      @(negedge sys_clk);
      chk(rx_data, exp, "rx_data");
   endtask
   initial begin
      int r;
      repeat (20) @(negedge sys_clk);
      chk({framed_error, transmit_full_flag, receive_full_flag, buffer_element_count}, 16'h0000, "reset");
      reset_n = 1;
      for (r = 0; r < 4; r++) begin
         module_on_bit = 0;
         {prescale, clock_idle_high, word_mode, enhanced_buffer_select} = row[r][0][5:0];
         @(negedge sys_clk);
         module_on_bit = 1;
         wr(1, row[r][1]);
         rd(row[r][2]);
      end
      sleep_wake = 1;
      @(negedge sys_clk);
      sleep_wake = 0;
      rd(16'h0000);
      rd(16'h0000);
      wr(9, 16'h003C);
      @(negedge sys_clk);
      chk({11'h000, transmit_full_flag, buffer_element_count}, 16'h0008, "early full");
      repeat (9) rd(16'h00FF);
      chk({12'h000, buffer_element_count}, 16'h0000, "count");
      module_on_bit = 0;
      enhanced_buffer_select = 0;
      @(negedge sys_clk);
      module_on_bit = 1;
      sleep_wake = 1;
      @(negedge sys_clk);
      sleep_wake = 0;
      repeat (200) @(negedge sys_clk);
      chk({receive_full_flag, buffer_element_count}, 16'h0000, "normal wake");
      framed_mode_select = 1;
      wr(1, 16'h0055);
      chk({framed_error, buffer_element_count}, 16'h0010, "framed");
      print_verdict();
   end
endmodule
